// >>> hdl/cpaf_pkg.sv
// Constants, types and register map of the auto-run flag block
package cpaf_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int NAX  = 5;   // Controlled axes
   localparam int NPOS = 5;   // Primary, 1st, 2nd, 3rd, 4th reference position
   localparam int NPRM = 3;   // Permit bytes for the 2nd..4th position
   localparam int NAREA = 3;  // Z area flags

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCAN_TIME_NS  = 8_000_000;
   localparam int SCAN_CYC      = SCAN_TIME_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_RUN_IND   = 8'h00;
   localparam logic [7:0] OFF_FLAGS0    = 8'h04;  // Primary, then 1st..4th at +4 each
   localparam logic [7:0] OFF_Z_AREA    = 8'h18;
   localparam logic [7:0] OFF_DECEL     = 8'h1C;
   localparam logic [7:0] OFF_START_HLD = 8'h20;
   localparam logic [7:0] OFF_PERMIT0   = 8'h24;  // 2nd..4th at +4 each
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h30;
   localparam logic [7:0] OFF_IRQ_CLR   = 8'h34;
   localparam logic [7:0] OFF_IRQ_EN    = 8'h38;
   localparam logic [7:0] OFF_S1_LO     = 8'h3C;
   localparam logic [7:0] OFF_S1_HI     = 8'h40;
   localparam logic [7:0] OFF_S2_LO0    = 8'h44;  // Area k: low at +8k, high at +8k+4

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int BIT_FEED_HOLD = 7;
   localparam int BIT_CYCLE_GO  = 6;
   localparam int BIT_RUN_LAMP  = 7;
   localparam int BIT_GO_LAMP   = 5;
   localparam int BIT_HOLD_LAMP = 4;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   localparam int IRQ_W         = 7;
   localparam int IRQ_STARTED   = 0;
   localparam int IRQ_HELD      = 1;
   localparam int IRQ_RESET     = 2;
   localparam int IRQ_STOPPED   = 3;
   localparam int IRQ_IGNORED   = 4;
   localparam int IRQ_FLAG_SET  = 5;
   localparam int IRQ_AREA_CHG  = 6;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_STOP  = 2'b00,
      ST_GO    = 2'b01,
      ST_HOLD  = 2'b11,
      ST_RESET = 2'b10
   } cpaf_state_t;

   typedef struct packed {
      logic                       auto_mode;    // Memory, DNC or MDI selected
      logic                       alarm;
      logic                       reset_key;
      logic                       seq_search;
      logic                       program_restart_input;
      logic                       sblk_end;     // Pulse: block end in single block
      logic                       mdi_done;     // Pulse
      logic                       mode_end;     // Pulse: block end after mode change
      logic                       prog_end;     // Pulse
      logic [NAX-1:0]             in_pos;
      logic [NAX-1:0]             left_ref;
      logic [NAX-1:0]             servo_alarm;
      logic [NPOS-1:0][NAX-1:0]   ret_done;     // Pulses per position and axis
      logic signed [31:0]         z_pos;
   } cpaf_core_t;

   typedef struct packed {
      logic auto_running_lamp;
      logic cycle_go_lamp;
      logic feed_hold_lamp;
   } cpaf_lamps_t;

endpackage

// >>> hdl/cpaf_top.sv
// Auto-run state machine, reference and Z area flags behind APB
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps

// Functional notes
// - 2nd to 4th position end flags show only while their axis permit is 1.
// - One end flag per axis is kept for each of the 2nd, 3rd and 4th positions.
// - A permitted flag sets when the return of its own axis to its own position completes in position.
// - A flag clears on permit low, leaving, emergency stop or servo alarm.
// - Three Z area flags sit in bits 0 to 2 of the area byte.
// - An area flag is 1 inside stroke limit one and outside limit two.
// - Cycle start in memory, DNC or MDI mode enters the cycle-start state.
// - Cycle start is ignored off mode, on hold, stop, restart, reset, alarm, run or search.
// - Running, hold, block end, MDI end, alarm or mode end enter feed hold.
// - Running, emergency stop or reset key enter the reset state.
// - Feed hold while running drops the go lamp and lights the hold lamp.
// - Release of hold does not resume; a new cycle start rise is needed.
// - Lamps go,hold,run read 101 running, 011 on hold, 000 stopped or reset.
module cpaf_top
   import cpaf_pkg::*;
#(
   parameter int SCAN_CYCLES = cpaf_pkg::SCAN_CYC
)(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic [7:0]           paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire cpaf_pkg::cpaf_core_t core,
   input  wire logic                 emergency_stop_pin,
   output logic [cpaf_pkg::NAX-1:0]  ref_slow,
   output cpaf_pkg::cpaf_lamps_t     lamps,
   output logic                      irq
);
   import cpaf_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [31:0]               scan_cnt_r;
   logic                      tick;
   logic [2:0]                esp_s_r;
   logic                      esp_r;
   logic [7:0]                decel_r;
   logic [7:0]                sh_r;
   logic [NPRM-1:0][7:0]      permit_r;
   logic [NPRM-1:0][NAX-1:0]  permit_q_r;
   logic [IRQ_W-1:0]          irq_en_r;
   logic [IRQ_W-1:0]          irq_st_r;
   logic [IRQ_W-1:0]          ev;
   logic signed [31:0]        s1_lo_r;
   logic signed [31:0]        s1_hi_r;
   logic signed [31:0]        s2_lo_r [NAREA];
   logic signed [31:0]        s2_hi_r [NAREA];
   logic [3:0]                pend_r;
   logic [3:0]                pend;
   logic                      go_prev_r;
   logic                      go_rise;
   logic                      stop_req;
   logic                      ign;
   cpaf_state_t               state_r;
   cpaf_state_t               state_nxt;
   logic [NPOS-1:0][NAX-1:0]  perm;
   logic [NPOS-1:0][NAX-1:0]  flag_r;
   logic [NPOS-1:0][NAX-1:0]  flag_out_r;
   logic [NAREA-1:0]          area;
   logic [NAREA-1:0]          area_r;
   logic                      wr;
   logic [31:0]               rdata_nxt;
   logic                      hit;

   // ------------------------------------------------------------
   // Scan timing and emergency stop synchroniser
   // ------------------------------------------------------------
   // One tick for all PLC-visible state: no torn bytes
   assign tick = (scan_cnt_r == 32'(SCAN_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         scan_cnt_r <= 32'h0000_0000;
      else if (tick)
         scan_cnt_r <= 32'h0000_0000;
      else
         scan_cnt_r <= scan_cnt_r + 32'h0000_0001;

   // Level accepted only when the last two stages agree
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         esp_s_r <= 3'h0;
         esp_r   <= 1'b0;
      end
      else
      begin
         esp_s_r <= {esp_s_r[1:0], emergency_stop_pin};
         if (esp_s_r[1] == esp_s_r[2])
            esp_r <= esp_s_r[2];
      end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // Zero waits; read data fetched in setup
   assign pready = psel & penable;
   assign wr     = psel & penable & pwrite;

   always_comb
   begin
      rdata_nxt = RST_WORD;
      hit       = 1'b1;
      unique case (paddr)
         OFF_RUN_IND:   rdata_nxt[7:0] = {lamps.auto_running_lamp, 1'b0, lamps.cycle_go_lamp,
                                          lamps.feed_hold_lamp, 4'h0};
         OFF_Z_AREA:    rdata_nxt[NAREA-1:0] = area_r;
         OFF_DECEL:     rdata_nxt[7:0] = decel_r;
         OFF_START_HLD: rdata_nxt[7:0] = sh_r;
         OFF_IRQ_STAT:  rdata_nxt[IRQ_W-1:0] = irq_st_r;
         OFF_IRQ_CLR:   rdata_nxt = RST_WORD;
         OFF_IRQ_EN:    rdata_nxt[IRQ_W-1:0] = irq_en_r;
         OFF_S1_LO:     rdata_nxt = s1_lo_r;
         OFF_S1_HI:     rdata_nxt = s1_hi_r;
         default:       hit = 1'b0;
      endcase
      for (int p = 0; p < NPOS; p++)
         if (paddr == OFF_FLAGS0 + 8'(4 * p))
         begin
            rdata_nxt[NAX-1:0] = flag_out_r[p];
            hit = 1'b1;
         end
      for (int k = 0; k < NPRM; k++)
         if (paddr == OFF_PERMIT0 + 8'(4 * k))
         begin
            rdata_nxt[7:0] = permit_r[k];
            hit = 1'b1;
         end
      for (int k = 0; k < NAREA; k++)
      begin
         if (paddr == OFF_S2_LO0 + 8'(8 * k))
         begin
            rdata_nxt = s2_lo_r[k];
            hit = 1'b1;
         end
         if (paddr == OFF_S2_LO0 + 8'(8 * k + 4))
         begin
            rdata_nxt = s2_hi_r[k];
            hit = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         prdata  <= RST_WORD;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata  <= pwrite ? RST_WORD : rdata_nxt;
         pslverr <= ~hit;
      end

   // Writes; read-only offsets ignore them
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         decel_r  <= RST_BYTE;
         sh_r     <= RST_BYTE;
         permit_r <= '0;
         irq_en_r <= '0;
         s1_lo_r  <= RST_WORD;
         s1_hi_r  <= RST_WORD;
         for (int k = 0; k < NAREA; k++)
         begin
            s2_lo_r[k] <= RST_WORD;
            s2_hi_r[k] <= RST_WORD;
         end
      end
      else if (wr)
      begin
         if (paddr == OFF_DECEL)
            decel_r <= pwdata[7:0];
         if (paddr == OFF_START_HLD)
            sh_r <= pwdata[7:0];
         if (paddr == OFF_IRQ_EN)
            irq_en_r <= pwdata[IRQ_W-1:0];
         if (paddr == OFF_S1_LO)
            s1_lo_r <= pwdata;
         if (paddr == OFF_S1_HI)
            s1_hi_r <= pwdata;
         for (int k = 0; k < NPRM; k++)
            if (paddr == OFF_PERMIT0 + 8'(4 * k))
               permit_r[k] <= pwdata[7:0];
         for (int k = 0; k < NAREA; k++)
         begin
            if (paddr == OFF_S2_LO0 + 8'(8 * k))
               s2_lo_r[k] <= pwdata;
            if (paddr == OFF_S2_LO0 + 8'(8 * k + 4))
               s2_hi_r[k] <= pwdata;
         end
      end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   // An event in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         irq_st_r <= '0;
      else if (wr && paddr == OFF_IRQ_CLR)
         irq_st_r <= (irq_st_r & ~pwdata[IRQ_W-1:0]) | ev;
      else
         irq_st_r <= irq_st_r | ev;

   assign irq = |(irq_st_r & irq_en_r);

   // ------------------------------------------------------------
   // Automatic operation state machine
   // ------------------------------------------------------------
   // Core pulses held until the next tick
   assign pend = pend_r | {core.prog_end, core.mode_end, core.mdi_done, core.sblk_end};

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         pend_r <= 4'h0;
      else if (tick)
         pend_r <= 4'h0;
      else
         pend_r <= pend;

   assign go_rise  = sh_r[BIT_CYCLE_GO] & ~go_prev_r;
   assign stop_req = esp_r | core.reset_key;
   assign ign      = ~core.auto_mode | sh_r[BIT_FEED_HOLD] | esp_r
                     | core.program_restart_input | core.reset_key
                     | core.alarm | core.seq_search;

   always_comb
   begin
      state_nxt = state_r;
      if (tick)
         unique case (state_r)
            ST_STOP:
               if (stop_req)
                  state_nxt = ST_RESET;
               else if (go_rise && !ign)
                  state_nxt = ST_GO;
            ST_GO:
               if (stop_req)
                  state_nxt = ST_RESET;
               else if (sh_r[BIT_FEED_HOLD] || core.alarm || (|pend[2:0]))
                  state_nxt = ST_HOLD;
               else if (pend[3])
                  state_nxt = ST_STOP;
            ST_HOLD:
               if (stop_req)
                  state_nxt = ST_RESET;
               else if (go_rise && !ign)
                  state_nxt = ST_GO;
            ST_RESET:
               if (!stop_req)
                  state_nxt = ST_STOP;
         endcase
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         state_r   <= ST_STOP;
         go_prev_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (tick)
            go_prev_r <= sh_r[BIT_CYCLE_GO];
      end

   // Lamps follow the state
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         lamps <= '0;
      else if (tick)
      begin
         lamps.cycle_go_lamp     <= (state_nxt == ST_GO);
         lamps.feed_hold_lamp    <= (state_nxt == ST_HOLD);
         lamps.auto_running_lamp <= (state_nxt == ST_GO) || (state_nxt == ST_HOLD);
      end

   // Slow-down request, refreshed each scan
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ref_slow <= '0;
      else if (tick)
         ref_slow <= decel_r[NAX-1:0];

   // ------------------------------------------------------------
   // Reference position end flags
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         permit_q_r <= '0;
      else
         for (int k = 0; k < NPRM; k++)
            permit_q_r[k] <= permit_r[k][NAX-1:0];

   // Primary and 1st positions need no permit
   assign perm = {permit_q_r, {(2 * NAX){1'b1}}};

   genvar gp;
   generate
      for (gp = 0; gp < NPOS; gp++)
      begin : g_pos
         // Completion beats a same-cycle leave;
         // permit low and emergency stop win
         always_ff @(posedge pclk or negedge presetn)
            if (!presetn)
               flag_r[gp] <= '0;
            else
               flag_r[gp] <= perm[gp] & {NAX{~esp_r}}
                             & ((core.ret_done[gp] & core.in_pos)
                                | (flag_r[gp] & ~core.left_ref & ~core.servo_alarm));
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         flag_out_r <= '0;
      else if (tick)
         flag_out_r <= flag_r & perm;

   // ------------------------------------------------------------
   // Z area flags
   // ------------------------------------------------------------
   genvar ga;
   generate
      for (ga = 0; ga < NAREA; ga++)
      begin : g_area
         assign area[ga] = (core.z_pos >= s1_lo_r) && (core.z_pos <= s1_hi_r)
                           && ((core.z_pos < s2_lo_r[ga]) || (core.z_pos > s2_hi_r[ga]));
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         area_r <= '0;
      else if (tick)
         area_r <= area;

   // ------------------------------------------------------------
   // Interrupt events
   // ------------------------------------------------------------
   always_comb
   begin
      ev = '0;
      ev[IRQ_STARTED]  = tick && state_nxt == ST_GO && state_r != ST_GO;
      ev[IRQ_HELD]     = tick && state_nxt == ST_HOLD && state_r != ST_HOLD;
      ev[IRQ_RESET]    = tick && state_nxt == ST_RESET && state_r != ST_RESET;
      ev[IRQ_STOPPED]  = tick && state_nxt == ST_STOP && state_r != ST_STOP;
      ev[IRQ_IGNORED]  = tick && go_rise && (ign || state_r == ST_GO);
      ev[IRQ_FLAG_SET] = tick && (|(flag_r & perm & ~flag_out_r));
      ev[IRQ_AREA_CHG] = tick && (area != area_r);
   end

endmodule // cpaf_top

// >>> sim/cpaf_top_sva.sv
// Port checks of the auto-run flag block
`timescale 1ns/10ps
module cpaf_chk
   import cpaf_pkg::*;
#(
   parameter int SCAN_CYCLES = 16
)(
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic [7:0]               paddr,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [31:0]              pwdata,
   input wire logic [31:0]              prdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire cpaf_pkg::cpaf_core_t     core,
   input wire logic                     emergency_stop_pin,
   input wire logic [cpaf_pkg::NAX-1:0] ref_slow,
   input wire cpaf_pkg::cpaf_lamps_t    lamps,
   input wire logic                     irq
);
   int         cnt;
   int         hw;
   int         esp_n;
   logic       go_r;
   logic       hold_r;
   logic       tgo_r;
   logic [4:0] dec_r;
   logic       wr_en;
   assign wr_en = psel && penable && pwrite;

   // Scan phase from reset release
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         cnt <= 0;
      else
         cnt <= (cnt == SCAN_CYCLES - 1) ? 0 : cnt + 1;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         go_r   <= 1'b0;
         hold_r <= 1'b0;
         dec_r  <= 5'h00;
      end
      else
      begin
         if (wr_en && paddr == OFF_START_HLD)
         begin
            go_r   <= pwdata[BIT_CYCLE_GO];
            hold_r <= pwdata[BIT_FEED_HOLD];
         end
         if (wr_en && paddr == OFF_DECEL)
            dec_r <= pwdata[4:0];
      end

   // Start bit at the previous tick
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         tgo_r <= 1'b0;
      else if (cnt == SCAN_CYCLES - 1)
         tgo_r <= go_r;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         hw <= 0;
      else
         hw <= (hold_r && lamps.cycle_go_lamp) ? hw + 1 : 0;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         esp_n <= 0;
      else if (!emergency_stop_pin)
         esp_n <= 0;
      else if (esp_n < 2 * SCAN_CYCLES + 8)
         esp_n <= esp_n + 1;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_tick;
      $past(cnt) == SCAN_CYCLES - 1;
   endsequence
   sequence s_enter_go;
      $rose(lamps.cycle_go_lamp);
   endsequence

   a_lamp_code: assert property (lamps inside {3'b000, 3'b110, 3'b101})
      else $error("lamp pattern illegal");
   a_lamp_tick: assert property (!$stable(lamps) |-> s_tick)
      else $error("lamps off tick");
   a_slow_copy: assert property (s_tick |-> ref_slow == $past(dec_r))
      else $error("slow-down mismatch");
   a_hold_from_go: assert property ($rose(lamps.feed_hold_lamp) |-> $past(lamps.cycle_go_lamp))
      else $error("hold not from run");
   a_go_allowed: assert property (s_enter_go |-> $past(go_r && !hold_r && core.auto_mode
      && !core.alarm && !core.reset_key && !core.seq_search && !core.program_restart_input))
      else $error("barred start taken");
   a_go_fresh_edge: assert property (s_enter_go |-> !$past(tgo_r))
      else $error("run without fresh start");
   a_hold_bound: assert property (hw <= SCAN_CYCLES + 1)
      else $error("hold late");
   a_esp_reset: assert property (esp_n >= 2 * SCAN_CYCLES + 4 |-> lamps == 3'b000)
      else $error("lamps lit in stop");
endmodule // cpaf_chk

bind cpaf_top cpaf_chk #(.SCAN_CYCLES(SCAN_CYCLES)) chk (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core),
   .emergency_stop_pin(emergency_stop_pin), .ref_slow(ref_slow), .lamps(lamps), .irq(irq));

// >>> sim/cpaf_plc_model.sv
// PLC model: APB master for input and flag bytes
`timescale 1ns/10ps
module cpaf_plc_model
   import cpaf_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic [7:0]       paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      pwdata,
   output logic             last_err,
   output logic             hung
);
   initial
   begin
      {paddr, psel, penable, pwrite, pwdata, last_err, hung} = '0;
   end

   // Called just after a rising edge; idle edge after each transfer
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= d;
      psel    <= 1'b1;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      q = prdata;
      last_err <= pslverr;
      hung     <= (n >= 16);
      psel     <= 1'b0;
      penable  <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0000_0000, q);
   endtask

   // Hold drops before the new start edge
   task automatic resume(input int gap);
      wr(OFF_START_HLD, 32'h0000_0000);
      repeat (gap) @(posedge pclk);
      wr(OFF_START_HLD, 32'h0000_0040);
      repeat (gap) @(posedge pclk);
      wr(OFF_START_HLD, 32'h0000_0000);
   endtask
endmodule // cpaf_plc_model

// >>> sim/tb.sv
// Bench for the auto-run flag block
`timescale 1ns/10ps
module tb;
   import cpaf_pkg::*;
   localparam int SC = 16;
   localparam int WT = SC + 2;
   logic               pclk;
   logic               presetn;
   logic [7:0]         paddr;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   cpaf_core_t         core;
   logic               emergency_stop;
   logic [NAX-1:0]     ref_slow;
   cpaf_lamps_t        lamps;
   logic               irq;
   logic               last_err;
   logic               hung;
   logic [31:0]        q;
   int                 n_fail;
   int                 samples_checked;
   logic signed [31:0] lim [8] = '{-100, 100, 10, 20, -50, 50, 200, 300};
   logic signed [31:0] zs [5] = '{15, 60, -100, 101, 10};

   always #10 pclk = ~pclk;

   cpaf_top #(.SCAN_CYCLES(SC)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .core(core), .emergency_stop_pin(emergency_stop),
      .ref_slow(ref_slow), .lamps(lamps), .irq(irq));
   cpaf_plc_model plc (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .last_err(last_err), .hung(hung));

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      plc.rd(a, q);
      check($sformatf("reg %h", a), q, e);
   endtask

   task automatic tick;
      repeat (WT) @(posedge pclk);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [31:0] area_exp(input logic signed [31:0] z);
      logic [31:0] e;
      e = '0;
      for (int k = 0; k < NAREA; k++)
         e[k] = z >= lim[0] && z <= lim[1] && (z < lim[2*k+2] || z > lim[2*k+3]);
      return e;
   endfunction

   // Hangs end in the closing report
   always @(posedge hung)
   begin
      n_fail++;
      final_report();
   end

   initial
   begin
      repeat (100000) @(posedge pclk);
      n_fail++;
      final_report();
   end

   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      emergency_stop = 1'b0;
      core = '0;
      core.auto_mode = 1'b1;
      n_fail = 0;
      samples_checked = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 0; a <= 'h38; a += 4)
         rd_chk(a[7:0], RST_WORD);
      check("lamps", 32'(lamps), 32'h0);
      plc.rd(8'hFC, q);
      check("unmapped err", 32'(last_err), 32'h1);
      plc.wr(OFF_RUN_IND, 32'h0000_00FF);
      rd_chk(OFF_RUN_IND, 32'h0000_0000);
      $display("test reset_bus done");
      plc.wr(OFF_DECEL, 32'h0000_0015);
      tick();
      check("ref_slow", 32'(ref_slow), 32'h15);
      rd_chk(OFF_DECEL, 32'h0000_0015);
      plc.wr(OFF_IRQ_EN, 32'h0000_007F);
      plc.wr(OFF_START_HLD, 32'h0000_0040);
      tick();
      rd_chk(OFF_RUN_IND, 32'h0000_00A0);
      check("irq", 32'(irq), 32'h1);
      rd_chk(OFF_IRQ_STAT, 32'h0000_0001);
      plc.wr(OFF_IRQ_CLR, 32'h0000_007F);
      @(posedge pclk);
      check("irq", 32'(irq), 32'h0);
      plc.wr(OFF_START_HLD, 32'h0000_00C0);
      tick();
      rd_chk(OFF_RUN_IND, 32'h0000_0090);
      plc.wr(OFF_START_HLD, 32'h0000_0040);
      tick();
      check("no resume", 32'(lamps), 32'h5);
      plc.resume(WT);
      tick();
      check("resumed", 32'(lamps), 32'h6);
      plc.wr(OFF_IRQ_CLR, 32'h0000_007F);
      plc.wr(OFF_START_HLD, 32'h0000_0040);
      tick();
      rd_chk(OFF_IRQ_STAT, 32'h0000_0010);
      core.prog_end <= 1'b1;
      @(posedge pclk);
      core.prog_end <= 1'b0;
      plc.wr(OFF_START_HLD, 32'h0000_0000);
      tick();
      check("stopped", 32'(lamps), 32'h0);
      $display("test run_hold done");
      for (int c = 0; c < 6; c++)
      begin
         core.auto_mode <= (c != 0);
         core.alarm <= (c == 1);
         core.reset_key <= (c == 2);
         core.seq_search <= (c == 3);
         core.program_restart_input <= (c == 4);
         plc.wr(OFF_START_HLD, (c == 5) ? 32'h0000_00C0 : 32'h0000_0040);
         tick();
         check("start barred", 32'(lamps), 32'h0);
         plc.wr(OFF_START_HLD, 32'h0000_0000);
         tick();
      end
      $display("test start_barred done");
      plc.wr(OFF_IRQ_EN, 32'h0000_0000);
      plc.wr(OFF_START_HLD, 32'h0000_0040);
      tick();
      check("masked irq", 32'(irq), 32'h0);
      plc.wr(OFF_IRQ_EN, 32'h0000_0001);
      @(posedge pclk);
      check("unmasked irq", 32'(irq), 32'h1);
      emergency_stop <= 1'b1;
      repeat (2 * WT + 4) @(posedge pclk);
      check("esp lamps", 32'(lamps), 32'h0);
      emergency_stop <= 1'b0;
      plc.wr(OFF_START_HLD, 32'h0000_0000);
      plc.wr(OFF_IRQ_CLR, 32'h0000_007F);
      @(posedge pclk);
      check("cleared irq", 32'(irq), 32'h0);
      $display("test esp_irq done");
      plc.wr(OFF_PERMIT0, 32'h0000_001F);
      core.in_pos <= 5'h1F;
      tick();
      core.ret_done[2] <= 5'h1F;
      core.ret_done[3] <= 5'h1F;
      @(posedge pclk);
      core.ret_done <= '0;
      tick();
      rd_chk(OFF_FLAGS0 + 8'h08, 32'h0000_001F);
      rd_chk(OFF_FLAGS0 + 8'h0C, 32'h0000_0000);
      plc.wr(OFF_PERMIT0, 32'h0000_001E);
      core.left_ref <= 5'h02;
      core.servo_alarm <= 5'h04;
      tick();
      rd_chk(OFF_FLAGS0 + 8'h08, 32'h0000_0018);
      core.left_ref <= 5'h00;
      core.servo_alarm <= 5'h00;
      emergency_stop <= 1'b1;
      repeat (2 * WT) @(posedge pclk);
      rd_chk(OFF_FLAGS0 + 8'h08, 32'h0000_0000);
      emergency_stop <= 1'b0;
      $display("test ref_flags done");
      for (int i = 0; i < 8; i++)
         plc.wr(OFF_S1_LO + 8'(4 * i), lim[i]);
      foreach (zs[i])
      begin
         core.z_pos <= zs[i];
         tick();
         rd_chk(OFF_Z_AREA, area_exp(zs[i]));
      end
      $display("test z_area done");
      final_report();
   end
endmodule // tb
